// ### core/dalc_pkg.sv
// constants for the link, audio and equalizer control register slice
// assumes byte-wide register access from the i2c target logic
// Overview of operation
// R1 - overflow flag in audio control bit 3
// R2 - underflow flag in audio control bit 2
// R3 - writing one to bit 1 clears errors
// R4 - bit 0 picks rising or falling strobe
// R5 - pixel clock bit 7 selects test clock
// R6 - lock mode zero: lock only with video
// R7 - lock mode one: lock whenever linked
// R8 - raw back channel forwards gpio zero unfiltered
// R9 - input mode field picks link configuration
// R10 - second port select writes port one registers
// R11 - host clears second select before port zero reads
// R12 - first port select resets one, steers access
// R13 - both selects set: reads return port one
// R14 - restart bit held high restarts adaptation
// R15 - override bit gates the floor apply bit
// R16 - floor apply uses level from 0x45
// R17 - video disabled means control only, no video
// R18 - reserved bits stay zero, writes ignored
package dalc_pkg;
    // register offsets
    localparam logic [7:0] DALC_AUDIO_CTRL_ADDR = 8'h2b;
    localparam logic [7:0] DALC_PCLK_TEST_ADDR = 8'h2e;
    localparam logic [7:0] DALC_DUAL_RX_ADDR = 8'h34;
    localparam logic [7:0] DALC_EQ_CTRL1_ADDR = 8'h35;
    localparam logic [7:0] DALC_EQ_CTRL2_ADDR = 8'h45;

    // reset values
    localparam logic [7:0] DALC_AUDIO_CTRL_RST = 8'h00;
    localparam logic [7:0] DALC_PCLK_TEST_RST = 8'h00;
    localparam logic [7:0] DALC_DUAL_RX_RST = 8'h01;
    localparam logic [7:0] DALC_EQ_CTRL1_RST = 8'h00;

    // audio control fields
    localparam int DALC_AUD_OVERFLOW_BIT = 3;
    localparam int DALC_AUD_UNDERFLOW_BIT = 2;
    localparam int DALC_AUD_ERR_CLEAR_BIT = 1;
    localparam int DALC_AUD_RISING_BIT = 0;

    // pixel clock test field
    localparam int DALC_PCLK_EXT_BIT = 7;

    // dual receive fields
    localparam int DALC_RX_LOCK_MODE_BIT = 6;
    localparam int DALC_RAW_BC_BIT = 5;
    localparam int DALC_INPUT_MODE_HI = 4;
    localparam int DALC_INPUT_MODE_LO = 3;
    localparam int DALC_SECOND_PORT_ACCESS_SELECT_BIT = 1;
    localparam int DALC_FIRST_PORT_ACCESS_SELECT_BIT = 0;

    // equalizer control fields
    localparam int DALC_EQ_RESTART_BIT = 6;
    localparam int DALC_EQ_OVERRIDE_BIT = 5;
    localparam int DALC_EQ_APPLY_BIT = 4;

    // writable bit masks; everything else is reserved and reads zero, except audio control bits 3 and 2, which read the fifo flags
    localparam logic [7:0] DALC_AUDIO_CTRL_WMASK = 8'h03;
    localparam logic [7:0] DALC_PCLK_TEST_WMASK = 8'h80;
    localparam logic [7:0] DALC_DUAL_RX_WMASK = 8'h7b;
    localparam logic [7:0] DALC_EQ_CTRL1_WMASK = 8'h70;

    // link input configuration codes
    typedef enum logic [1:0] {
        DALC_MODE_AUTO = 2'h0,
        DALC_MODE_DUAL = 2'h1,
        DALC_MODE_SINGLE_PRIMARY = 2'h2,
        DALC_MODE_SINGLE_SECONDARY = 2'h3
    } dalc_input_mode_t;
endpackage

// ### core/dalc_audio_err.sv
// sticky audio fifo overflow and underflow flags
// assumes one-cycle event pulses from the audio fifo, same clock
`timescale 1ns/10ps
module dalc_audio_err (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // fifo events
    input wire logic overflow_event,
    input wire logic underflow_event,
    // software clear
    input wire logic error_clear,
    // sticky flags
    output logic overflow_q,
    output logic underflow_q
);
    // set wins over clear so an event in the clear cycle is kept
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            overflow_q <= 1'b0;
        end else if (overflow_event) begin
            overflow_q <= 1'b1; // [R1]
        end else if (error_clear) begin
            overflow_q <= 1'b0; // [R3]
        end
    end

    // same policy for underflow
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            underflow_q <= 1'b0;
        end else if (underflow_event) begin
            underflow_q <= 1'b1; // [R2]
        end else if (error_clear) begin
            underflow_q <= 1'b0; // [R3]
        end
    end

    // event must leave the flag set even under a clear
    overflow_set_a: assert property (@(posedge clock) disable iff (reset)
        overflow_event |=> overflow_q) else $error("overflow event lost"); // [R1]
    underflow_set_a: assert property (@(posedge clock) disable iff (reset)
        underflow_event |=> underflow_q) else $error("underflow event lost"); // [R2]
    error_clear_a: assert property (@(posedge clock) disable iff (reset)
        error_clear && !overflow_event && !underflow_event |=> !overflow_q && !underflow_q)
        else $error("fifo error clear ignored"); // [R3]
endmodule

// ### core/dalc_regs.sv
// control and status register slice: audio, pixel clock, dual receive, equalizer
// assumes the i2c target hands over byte accesses as one-cycle strobes
// and decodes whether an address is a per-port register
`timescale 1ns/10ps
module dalc_regs (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register access from the i2c target
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic reg_addr_per_port,
    input wire logic [7:0] port0_rdata,
    input wire logic [7:0] port1_rdata,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // per-port register write steering
    output logic port0_write_q,
    output logic port1_write_q,
    output logic [7:0] port_waddr_q,
    output logic [7:0] port_wdata_q,
    // audio fifo
    input wire logic fifo_overflow_event,
    input wire logic fifo_underflow_event,
    output logic audio_fifo_error_reset_q,
    output logic audio_strobe_rising_q,
    // pixel clock source
    output logic pixel_clock_external_q,
    // link status and lock
    input wire logic link_linked,
    input wire logic fwd_active_video,
    input wire logic fwd_control_enabled,
    input wire logic link_detected_dual,
    input wire logic link_detected_secondary,
    output logic video_disabled_q,
    output logic rx_lock_q,
    // receive configuration
    output logic rx_dual_link_q,
    output logic rx_use_primary_q,
    output logic rx_use_secondary_q,
    // secondary back channel
    input wire logic general_purpose_input_zero,
    input wire logic gpio0_filtered,
    output logic raw_secondary_back_channel_q,
    output logic back_channel_gpio_q,
    // equalizer
    output logic equalizer_adaptation_restart_q,
    output logic equalizer_floor_active_q,
    output logic [7:0] equalizer_floor_addr_q
);
    import dalc_pkg::*;

    logic [7:0] audio_ctrl_q;
    logic [7:0] pclk_test_q;
    logic [7:0] dual_rx_q;
    logic [7:0] eq_ctrl1_q;
    logic overflow_flag;
    logic underflow_flag;
    logic shared_write;
    logic dual_rx_write;
    logic audio_clear_pulse;
    logic [7:0] shared_rdata;
    logic [7:0] audio_rdata;
    logic lock_d;
    dalc_input_mode_t mode_sel;

    // shared registers need a port selected, except the steering register itself
    // so that clearing both selects cannot lock the host out
    assign shared_write = reg_write && !reg_addr_per_port &&
        (dual_rx_q[DALC_FIRST_PORT_ACCESS_SELECT_BIT] || dual_rx_q[DALC_SECOND_PORT_ACCESS_SELECT_BIT]); // [R10] [R12]
    assign dual_rx_write = reg_write && !reg_addr_per_port && (reg_addr == DALC_DUAL_RX_ADDR);
    assign audio_clear_pulse = shared_write && (reg_addr == DALC_AUDIO_CTRL_ADDR) &&
        reg_wdata[DALC_AUD_ERR_CLEAR_BIT]; // [R3]
    assign mode_sel = dalc_input_mode_t'(dual_rx_q[DALC_INPUT_MODE_HI:DALC_INPUT_MODE_LO]);

    // sticky fifo error flags
    dalc_audio_err u_audio_err (
        .clock(clock),
        .reset(reset),
        .overflow_event(fifo_overflow_event),
        .underflow_event(fifo_underflow_event),
        .error_clear(audio_clear_pulse),
        .overflow_q(overflow_flag),
        .underflow_q(underflow_flag)
    );

    // audio control: only the two control bits are stored
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            audio_ctrl_q <= DALC_AUDIO_CTRL_RST;
        end else if (shared_write && reg_addr == DALC_AUDIO_CTRL_ADDR) begin
            audio_ctrl_q <= reg_wdata & DALC_AUDIO_CTRL_WMASK; // [R4] [R18]
        end
    end

    // pixel clock test select
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pclk_test_q <= DALC_PCLK_TEST_RST;
        end else if (shared_write && reg_addr == DALC_PCLK_TEST_ADDR) begin
            pclk_test_q <= reg_wdata & DALC_PCLK_TEST_WMASK; // [R5] [R18]
        end
    end

    // dual receive control, first port select comes up set
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dual_rx_q <= DALC_DUAL_RX_RST; // [R12]
        end else if (dual_rx_write) begin
            dual_rx_q <= reg_wdata & DALC_DUAL_RX_WMASK; // [R18]
        end
    end

    // equalizer control one
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            eq_ctrl1_q <= DALC_EQ_CTRL1_RST;
        end else if (shared_write && reg_addr == DALC_EQ_CTRL1_ADDR) begin
            eq_ctrl1_q <= reg_wdata & DALC_EQ_CTRL1_WMASK; // [R18]
        end
    end

    // per-port write steering: both selects may fan one write to both ports
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port0_write_q <= 1'b0;
            port1_write_q <= 1'b0;
            port_waddr_q <= 8'h00;
            port_wdata_q <= 8'h00;
        end else begin
            port0_write_q <= reg_write && reg_addr_per_port && dual_rx_q[DALC_FIRST_PORT_ACCESS_SELECT_BIT]; // [R12]
            port1_write_q <= reg_write && reg_addr_per_port && dual_rx_q[DALC_SECOND_PORT_ACCESS_SELECT_BIT]; // [R10]
            if (reg_write) begin
                port_waddr_q <= reg_addr;
                port_wdata_q <= reg_wdata;
            end
        end
    end

    // shared read data; status flags are inserted live
    always_comb begin
        audio_rdata = audio_ctrl_q;
        audio_rdata[DALC_AUD_OVERFLOW_BIT] = overflow_flag; // [R1]
        audio_rdata[DALC_AUD_UNDERFLOW_BIT] = underflow_flag; // [R2]
        unique case (reg_addr)
            DALC_AUDIO_CTRL_ADDR: shared_rdata = audio_rdata;
            DALC_PCLK_TEST_ADDR: shared_rdata = pclk_test_q;
            DALC_DUAL_RX_ADDR: shared_rdata = dual_rx_q;
            DALC_EQ_CTRL1_ADDR: shared_rdata = eq_ctrl1_q;
            default: shared_rdata = 8'h00;
        endcase
    end

    // read answer one cycle after the strobe; port one wins when both are selected
    // a host reading port zero must therefore drop the second select first
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_read;
            if (reg_read) begin
                if (!reg_addr_per_port) begin
                    reg_rdata_q <= shared_rdata;
                end else if (dual_rx_q[DALC_SECOND_PORT_ACCESS_SELECT_BIT]) begin
                    reg_rdata_q <= port1_rdata; // [R13] [R11]
                end else begin
                    reg_rdata_q <= port0_rdata; // [R12]
                end
            end
        end
    end

    // audio and pixel clock outputs; the clear level follows the stored bit
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            audio_fifo_error_reset_q <= 1'b0;
            audio_strobe_rising_q <= 1'b0;
            pixel_clock_external_q <= 1'b0;
        end else begin
            audio_fifo_error_reset_q <= audio_ctrl_q[DALC_AUD_ERR_CLEAR_BIT]; // [R3]
            audio_strobe_rising_q <= audio_ctrl_q[DALC_AUD_RISING_BIT]; // [R4]
            pixel_clock_external_q <= pclk_test_q[DALC_PCLK_EXT_BIT]; // [R5]
        end
    end

    // lock policy depends on whether video presence is required
    always_comb begin
        if (dual_rx_q[DALC_RX_LOCK_MODE_BIT]) begin
            lock_d = link_linked; // [R7]
        end else begin
            lock_d = link_linked && fwd_active_video; // [R6]
        end
    end

    // video disabled flag and lock indication
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            video_disabled_q <= 1'b0;
            rx_lock_q <= 1'b0;
        end else begin
            video_disabled_q <= !fwd_active_video && fwd_control_enabled; // [R17]
            rx_lock_q <= lock_d;
        end
    end

    // receive configuration from the input mode field
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_dual_link_q <= 1'b0;
            rx_use_primary_q <= 1'b0;
            rx_use_secondary_q <= 1'b0;
        end else begin
            unique case (mode_sel)
                DALC_MODE_AUTO: begin
                    rx_dual_link_q <= link_detected_dual; // [R9]
                    rx_use_primary_q <= link_detected_dual || !link_detected_secondary;
                    rx_use_secondary_q <= link_detected_dual || link_detected_secondary;
                end
                DALC_MODE_DUAL: begin
                    rx_dual_link_q <= 1'b1; // [R9]
                    rx_use_primary_q <= 1'b1;
                    rx_use_secondary_q <= 1'b1;
                end
                DALC_MODE_SINGLE_PRIMARY: begin
                    rx_dual_link_q <= 1'b0; // [R9]
                    rx_use_primary_q <= 1'b1;
                    rx_use_secondary_q <= 1'b0;
                end
                DALC_MODE_SINGLE_SECONDARY: begin
                    rx_dual_link_q <= 1'b0; // [R9]
                    rx_use_primary_q <= 1'b0;
                    rx_use_secondary_q <= 1'b1;
                end
            endcase
        end
    end

    // back channel source: raw pin or the filtered sample
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            raw_secondary_back_channel_q <= 1'b0;
            back_channel_gpio_q <= 1'b0;
        end else begin
            raw_secondary_back_channel_q <= dual_rx_q[DALC_RAW_BC_BIT];
            if (dual_rx_q[DALC_RAW_BC_BIT]) begin
                back_channel_gpio_q <= general_purpose_input_zero; // [R8]
            end else begin
                back_channel_gpio_q <= gpio0_filtered;
            end
        end
    end

    // equalizer: restart is a level, floor needs both override and apply
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            equalizer_adaptation_restart_q <= 1'b0;
            equalizer_floor_active_q <= 1'b0;
            equalizer_floor_addr_q <= 8'h00;
        end else begin
            equalizer_adaptation_restart_q <= eq_ctrl1_q[DALC_EQ_RESTART_BIT]; // [R14]
            equalizer_floor_active_q <= eq_ctrl1_q[DALC_EQ_OVERRIDE_BIT] &&
                eq_ctrl1_q[DALC_EQ_APPLY_BIT]; // [R15] [R16]
            equalizer_floor_addr_q <= DALC_EQ_CTRL2_ADDR; // [R16]
        end
    end

    // checks
    strobe_edge_a: assert property (@(posedge clock) disable iff (reset)
        shared_write && reg_addr == DALC_AUDIO_CTRL_ADDR |=>
        ##1 audio_strobe_rising_q == $past(reg_wdata[DALC_AUD_RISING_BIT], 2))
        else $error("strobe edge not taken from write"); // [R4]
    pclk_select_a: assert property (@(posedge clock) disable iff (reset)
        shared_write && reg_addr == DALC_PCLK_TEST_ADDR |=>
        ##1 pixel_clock_external_q == $past(reg_wdata[DALC_PCLK_EXT_BIT], 2))
        else $error("pixel clock select wrong"); // [R5]
    lock_video_a: assert property (@(posedge clock) disable iff (reset)
        !dual_rx_q[DALC_RX_LOCK_MODE_BIT] && !fwd_active_video |=> !rx_lock_q)
        else $error("lock without active video"); // [R6]
    lock_linked_a: assert property (@(posedge clock) disable iff (reset)
        dual_rx_q[DALC_RX_LOCK_MODE_BIT] && link_linked |=> rx_lock_q)
        else $error("lock missing while linked"); // [R7]
    raw_channel_a: assert property (@(posedge clock) disable iff (reset)
        dual_rx_q[DALC_RAW_BC_BIT] |=> back_channel_gpio_q == $past(general_purpose_input_zero))
        else $error("raw back channel not forwarded"); // [R8]
    mode_dual_a: assert property (@(posedge clock) disable iff (reset)
        mode_sel == DALC_MODE_DUAL |=> rx_dual_link_q && rx_use_primary_q && rx_use_secondary_q)
        else $error("forced dual mode not applied"); // [R9]
    mode_secondary_a: assert property (@(posedge clock) disable iff (reset)
        mode_sel == DALC_MODE_SINGLE_SECONDARY |=> !rx_dual_link_q && !rx_use_primary_q)
        else $error("secondary single mode wrong"); // [R9]
    port1_write_a: assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr_per_port |=> port1_write_q == $past(dual_rx_q[DALC_SECOND_PORT_ACCESS_SELECT_BIT]))
        else $error("port one write steering wrong"); // [R10]
    port0_write_a: assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr_per_port |=> port0_write_q == $past(dual_rx_q[DALC_FIRST_PORT_ACCESS_SELECT_BIT]))
        else $error("port zero write steering wrong"); // [R12]
    port1_read_a: assert property (@(posedge clock) disable iff (reset)
        reg_read && reg_addr_per_port && dual_rx_q[DALC_SECOND_PORT_ACCESS_SELECT_BIT] |=>
        reg_rvalid_q && reg_rdata_q == $past(port1_rdata))
        else $error("port one read not returned"); // [R13]
    eq_restart_a: assert property (@(posedge clock) disable iff (reset)
        eq_ctrl1_q[DALC_EQ_RESTART_BIT] [*2] |=> equalizer_adaptation_restart_q)
        else $error("restart level not held"); // [R14]
    floor_gate_a: assert property (@(posedge clock) disable iff (reset)
        !eq_ctrl1_q[DALC_EQ_OVERRIDE_BIT] |=> !equalizer_floor_active_q)
        else $error("floor applied without override"); // [R15]
    floor_apply_a: assert property (@(posedge clock) disable iff (reset)
        eq_ctrl1_q[DALC_EQ_OVERRIDE_BIT] && eq_ctrl1_q[DALC_EQ_APPLY_BIT] |=> equalizer_floor_active_q)
        else $error("floor not applied"); // [R16]
    video_flag_a: assert property (@(posedge clock) disable iff (reset)
        fwd_active_video |=> !video_disabled_q)
        else $error("video disabled during video"); // [R17]
    reserved_zero_a: assert property (@(posedge clock) disable iff (reset)
        (dual_rx_q & ~DALC_DUAL_RX_WMASK) == 8'h00 && (eq_ctrl1_q & ~DALC_EQ_CTRL1_WMASK) == 8'h00)
        else $error("reserved bits not zero"); // [R18]
endmodule

// ### test/dalc_host.sv
// host controller model driving the byte register port
// assumes strobes are taken on the rising edge and the answer comes one cycle later
`timescale 1ns/10ps
module dalc_host (
    // clock
    input wire logic clock,
    // register access
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    output logic reg_addr_per_port,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q
);
    // idle port from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr_per_port = 1'b0;
    end

    // one byte write; released qualifiers are inverted so nothing stale is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pp);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_addr_per_port = pp;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        reg_addr_per_port = ~pp;
    endtask

    // one byte read; data only counts when the valid strobe stands
    task automatic rd(input logic [7:0] a, input logic pp, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_addr_per_port = pp;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        reg_addr = ~a;
        reg_addr_per_port = ~pp;
        d = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hxx;
    endtask
endmodule

// ### test/tb.sv
// self-checking bench for the control and status register slice
// assumes the host model drives the register port at the falling edge
`timescale 1ns/10ps
module tb;
    import dalc_pkg::*;
    logic clock = 1'b0, reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, port_waddr_q, port_wdata_q, eq_addr, d;
    logic [7:0] port0_rdata = 8'ha5, port1_rdata = 8'h5a;
    logic reg_write, reg_read, pp, rvalid, p0w, p1w, ovf = 1'b0, unf = 1'b0, err_rst, rising;
    logic pclk_ext, linked = 1'b0, active = 1'b0, ctl_en = 1'b0, det_dual = 1'b0, det_sec = 1'b0;
    logic vid_dis, lock, dual, prim, sec, gpio0 = 1'b0, gpio0_f = 1'b0, raw_bc, bc_gpio, restart, floor;
    int n_errors = 0, checks_done = 0;

    always #5 clock = ~clock;

    dalc_host u_dalc_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr_per_port(pp),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(rvalid));

    dalc_regs u_dalc_regs (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr_per_port(pp),
        .port0_rdata(port0_rdata), .port1_rdata(port1_rdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(rvalid), .port0_write_q(p0w), .port1_write_q(p1w),
        .port_waddr_q(port_waddr_q), .port_wdata_q(port_wdata_q), .fifo_overflow_event(ovf),
        .fifo_underflow_event(unf), .audio_fifo_error_reset_q(err_rst),
        .audio_strobe_rising_q(rising), .pixel_clock_external_q(pclk_ext), .link_linked(linked),
        .fwd_active_video(active), .fwd_control_enabled(ctl_en), .link_detected_dual(det_dual),
        .link_detected_secondary(det_sec), .video_disabled_q(vid_dis), .rx_lock_q(lock),
        .rx_dual_link_q(dual), .rx_use_primary_q(prim), .rx_use_secondary_q(sec),
        .general_purpose_input_zero(gpio0), .gpio0_filtered(gpio0_f),
        .raw_secondary_back_channel_q(raw_bc), .back_channel_gpio_q(bc_gpio),
        .equalizer_adaptation_restart_q(restart), .equalizer_floor_active_q(floor),
        .equalizer_floor_addr_q(eq_addr));

    // one compare, counted
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // reset contents of all four registers
    task automatic t_reset();
        chk("floor_addr", eq_addr, 8'h45);
        u_dalc_host.rd(DALC_AUDIO_CTRL_ADDR, 1'b0, d);
        chk("audio", d, 8'h00);
        u_dalc_host.rd(DALC_PCLK_TEST_ADDR, 1'b0, d);
        chk("pclk", d, 8'h00);
        u_dalc_host.rd(DALC_DUAL_RX_ADDR, 1'b0, d);
        chk("dual_rx", d, 8'h01);
        u_dalc_host.rd(DALC_EQ_CTRL1_ADDR, 1'b0, d);
        chk("eq1", d, 8'h00);
    endtask

    // sticky fifo flags, clear, edge select, read-only and reserved bits
    task automatic t_audio();
        ovf <= 1'b1;
        step(1);
        ovf <= 1'b0;
        unf <= 1'b1;
        step(1);
        unf <= 1'b0;
        step(3);
        u_dalc_host.rd(DALC_AUDIO_CTRL_ADDR, 1'b0, d);
        chk("flags", d, 8'h0c);
        u_dalc_host.wr(DALC_AUDIO_CTRL_ADDR, 8'h02, 1'b0);
        u_dalc_host.rd(DALC_AUDIO_CTRL_ADDR, 1'b0, d);
        chk("cleared", d, 8'h02);
        chk("err_rst", {7'h00, err_rst}, 8'h01);
        u_dalc_host.wr(DALC_AUDIO_CTRL_ADDR, 8'hfd, 1'b0);
        u_dalc_host.rd(DALC_AUDIO_CTRL_ADDR, 1'b0, d);
        chk("audio_rsv", d, 8'h01);
        chk("rising", {7'h00, rising}, 8'h01);
        u_dalc_host.wr(DALC_AUDIO_CTRL_ADDR, 8'h00, 1'b0);
        step(1);
        chk("falling", {7'h00, rising}, 8'h00);
        u_dalc_host.wr(DALC_PCLK_TEST_ADDR, 8'hff, 1'b0);
        u_dalc_host.rd(DALC_PCLK_TEST_ADDR, 1'b0, d);
        chk("pclk_rsv", d, 8'h80);
        chk("pclk_ext", {7'h00, pclk_ext}, 8'h01);
    endtask

    // lock policy, video disabled flag, raw back channel
    task automatic t_link();
        linked <= 1'b1;
        ctl_en <= 1'b1;
        step(2);
        chk("vid_dis", {7'h00, vid_dis}, 8'h01);
        chk("lock_m0", {7'h00, lock}, 8'h00);
        active <= 1'b1;
        step(2);
        chk("lock_vid", {7'h00, lock}, 8'h01);
        chk("vid_en", {7'h00, vid_dis}, 8'h00);
        active <= 1'b0;
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'hc1, 1'b0);
        u_dalc_host.rd(DALC_DUAL_RX_ADDR, 1'b0, d);
        chk("rx_rsv", d, 8'h41);
        chk("lock_m1", {7'h00, lock}, 8'h01);
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h21, 1'b0);
        gpio0 <= 1'b1;
        step(2);
        chk("raw", {6'h00, raw_bc, bc_gpio}, 8'h03);
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h01, 1'b0);
        step(1);
        chk("filtered", {6'h00, raw_bc, bc_gpio}, 8'h00);
    endtask

    // every input configuration code
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h01 | 8'(m << 3), 1'b0);
            step(1);
            chk("dual", {7'h00, dual}, {7'h00, m == 1});
            if (m != 1) chk("single", {6'h00, prim, sec}, {6'h00, m != 3, m == 3});
        end
        // auto mode follows the detected link configuration
        det_dual <= 1'b1;
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h01, 1'b0);
        step(1);
        chk("auto_dual", {5'h00, dual, prim, sec}, 8'h07);
        det_dual <= 1'b0;
    endtask

    // per-port write steering and read selection
    task automatic t_ports();
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h03, 1'b0);
        u_dalc_host.wr(8'h10, 8'h77, 1'b1);
        chk("both_wr", {6'h00, p0w, p1w}, 8'h03);
        chk("wdata", port_wdata_q, 8'h77);
        chk("waddr", port_waddr_q, 8'h10);
        u_dalc_host.rd(8'h10, 1'b1, d);
        chk("rd_p1", d, 8'h5a);
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h01, 1'b0);
        u_dalc_host.wr(8'h11, 8'h3c, 1'b1);
        chk("p0_wr", {6'h00, p0w, p1w}, 8'h02);
        u_dalc_host.rd(8'h11, 1'b1, d);
        chk("rd_p0", d, 8'ha5);
        // with no port selected a shared write must not land
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h00, 1'b0);
        u_dalc_host.wr(DALC_PCLK_TEST_ADDR, 8'h00, 1'b0);
        u_dalc_host.rd(DALC_PCLK_TEST_ADDR, 1'b0, d);
        chk("no_sel_wr", d, 8'h80);
        u_dalc_host.wr(DALC_DUAL_RX_ADDR, 8'h01, 1'b0);
    endtask

    // restart level and gated floor apply
    task automatic t_eq();
        u_dalc_host.wr(DALC_EQ_CTRL1_ADDR, 8'h10, 1'b0);
        step(1);
        chk("floor_gate", {6'h00, restart, floor}, 8'h00);
        u_dalc_host.wr(DALC_EQ_CTRL1_ADDR, 8'hff, 1'b0);
        u_dalc_host.rd(DALC_EQ_CTRL1_ADDR, 1'b0, d);
        chk("eq_rsv", d, 8'h70);
        chk("restart", {6'h00, restart, floor}, 8'h03);
        u_dalc_host.wr(DALC_EQ_CTRL1_ADDR, 8'h00, 1'b0);
        step(1);
        chk("restart_lo", {7'h00, restart}, 8'h00);
    endtask

    // main sequence
    initial begin
        step(20);
        reset <= 1'b0;
        step(2);
        t_reset();
        t_audio();
        t_link();
        t_modes();
        t_ports();
        t_eq();
        close_out();
    end

    // watchdog well beyond the roughly 112 cycles of the run
    initial begin
        #100us;
        n_errors++;
        close_out();
    end
endmodule
